// ### src/fps_seq.sv
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - programming covers one 128-byte unit
// - wait 1 us after write enable set
// - wait 50 us after program setup
// - program pulse 30 us, or 200 us later
// - 10 us extra pulse on attempts 1-6
// - wait 5 us after pulse clear
// - wait 5 us after program setup clear
// - wait 4 us after program verify set
// - wait 2 us after dummy write
// - wait 2 us after program verify clear
// - wait 100 us after write enable clear
// - at most 1000 program attempts, then fail
// - wait 100 us after erase setup
// - erase pulse between 10 and 100 ms
// - wait 10 us after erase pulse clear
// - wait 10 us after erase setup clear
// - wait 20 us after erase verify set
// - wait 4 us after erase verify clear
// - at most 120 erase attempts, then fail
//////////////////////////////////////////////////////////////////////////////
module fps_seq
  import fps_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PSU_SET_CYC = CYC_PSU_SET,
  parameter int P_LONG_CYC = CYC_P_LONG,
  parameter int SWE_CLR_CYC = CYC_SWE_CLR,
  parameter int ESU_SET_CYC = CYC_ESU_SET,
  parameter int E_PULSE_CYC = CYC_E_PULSE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic software_write_enable_bit,
  output logic program_setup_bit,
  output logic program_pulse_bit,
  output logic program_verify_bit,
  output logic erase_setup_bit,
  output logic erase_pulse_bit,
  output logic erase_verify_bit,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_write,
  output logic flash_read,
  input wire logic [7:0] flash_rdata
);

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(UNIT_BYTES - 1);

  fps_state_t state_reg, state_next;
  logic [TMR_W-1:0] timer_reg, timer_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic [ATT_W-1:0] att_reg, att_next;
  logic erase_reg, erase_next;
  logic miss_reg, miss_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic swe_reg, swe_next, psu_reg, psu_next, p_reg, p_next, pv_reg, pv_next;
  logic esu_reg, esu_next, e_reg, e_next, ev_reg, ev_next;
  logic [ADDR_W-1:0] faddr_reg, faddr_next;
  logic [7:0] fwdata_reg, fwdata_next;
  logic fwr_reg, fwr_next, frd_reg, frd_next;
  logic [31:0] base_reg, base_next;
  logic [IDX_W-1:0] bufidx_reg, bufidx_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] rd_meta_reg, rd_sync_reg;
  logic [7:0] buf_rdata;
  logic bus_req, bus_acc, buf_we, start_prog, start_erase;

  // program pulse length for a given attempt number
  function automatic logic [TMR_W-1:0] pulse_cyc(input logic [ATT_W-1:0] att);
    pulse_cyc = (att <= ATT_W'(SHORT_ATTEMPTS)) ? TMR_W'(CYC_P_SHORT) : TMR_W'(P_LONG_CYC);
  endfunction

  // flash address of the current byte in the unit
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [31:0] base,
                                                  input logic [IDX_W-1:0] idx);
    byte_addr = ADDR_W'(base) + ADDR_W'(idx);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer at the second edge
  assign bus_req = avs_read | avs_write;
  assign bus_acc = bus_req & ~wait_reg;
  assign buf_we = bus_acc & avs_write & (avs_address == REG_BUFDATA);
  assign start_prog = bus_acc & avs_write & (avs_address == REG_CTRL)
                      & avs_writedata[CTRL_PROG_BIT] & ~busy_reg;
  assign start_erase = bus_acc & avs_write & (avs_address == REG_CTRL)
                       & avs_writedata[CTRL_ERASE_BIT] & ~avs_writedata[CTRL_PROG_BIT]
                       & ~busy_reg;

  // register file next values
  always_comb begin
    wait_next = ~(bus_req & wait_reg);
    rdata_next = rdata_reg;
    base_next = base_reg;
    bufidx_next = bufidx_reg;
    if (bus_req && wait_reg && avs_read) begin
      rdata_next = 32'h0000_0000;
      case (avs_address)
        REG_STATUS: begin
          rdata_next[STAT_BUSY_BIT] = busy_reg;
          rdata_next[STAT_DONE_BIT] = done_reg;
          rdata_next[STAT_FAIL_BIT] = fail_reg;
          rdata_next[STAT_ERASE_BIT] = erase_reg;
          rdata_next[STAT_ATT_LSB +: ATT_W] = att_reg;
        end
        REG_BASE: rdata_next = base_reg;
        REG_BUFIDX: rdata_next[IDX_W-1:0] = bufidx_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (bus_acc && avs_write && !busy_reg) begin
      case (avs_address)
        REG_BASE: base_next = avs_writedata;
        REG_BUFIDX: bufidx_next = avs_writedata[IDX_W-1:0];
        default: bufidx_next = bufidx_reg;
      endcase
    end
    if (buf_we) begin
      bufidx_next = bufidx_reg + 1'b1; // auto-increment on data writes
    end
  end

  // register file storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      base_reg <= BASE_RST;
      bufidx_reg <= BUFIDX_RST;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      base_reg <= base_next;
      bufidx_reg <= bufidx_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // expected data for one 128-byte unit
  fps_buf #(.WIDTH(8), .DEPTH(UNIT_BYTES), .AW(IDX_W)) u_buf (
    .clk(clk),
    .wr_en(buf_we),
    .wr_addr(bufidx_reg),
    .wr_data(avs_writedata[7:0]),
    .rd_addr(idx_reg),
    .rd_data(buf_rdata)
  );

  // read data from the device pins, two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_meta_reg <= 8'h00;
      rd_sync_reg <= 8'h00;
    end else begin
      rd_meta_reg <= flash_rdata;
      rd_sync_reg <= rd_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    timer_next = (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
    idx_next = idx_reg;
    att_next = att_reg;
    erase_next = erase_reg;
    miss_next = miss_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    swe_next = swe_reg;
    psu_next = psu_reg;
    p_next = p_reg;
    pv_next = pv_reg;
    esu_next = esu_reg;
    e_next = e_reg;
    ev_next = ev_reg;
    faddr_next = faddr_reg;
    fwdata_next = fwdata_reg;
    fwr_next = 1'b0;
    frd_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_prog || start_erase) begin
          erase_next = start_erase;
          att_next = '0;
          busy_next = 1'b1;
          done_next = 1'b0;
          fail_next = 1'b0;
          swe_next = 1'b1;
          timer_next = TMR_W'(CYC_SWE_SET);
          state_next = ST_SWE_ON;
        end
      end
      ST_SWE_ON: begin
        if (timer_reg == '0) begin
          att_next = ATT_W'(1);
          idx_next = '0;
          if (erase_reg) begin
            esu_next = 1'b1;
            timer_next = TMR_W'(ESU_SET_CYC);
            state_next = ST_SETUP_ON;
          end else begin
            state_next = ST_LOAD_RD;
          end
        end
      end
      ST_LOAD_RD: state_next = ST_LOAD_WR;
      ST_LOAD_WR: begin
        fwr_next = 1'b1;
        faddr_next = byte_addr(base_reg, idx_reg);
        fwdata_next = buf_rdata;
        if (idx_reg == LAST_IDX) begin
          psu_next = 1'b1;
          timer_next = TMR_W'(PSU_SET_CYC);
          state_next = ST_SETUP_ON;
        end else begin
          idx_next = idx_reg + 1'b1;
          state_next = ST_LOAD_RD;
        end
      end
      ST_SETUP_ON: begin
        if (timer_reg == '0) begin
          if (erase_reg) begin
            e_next = 1'b1;
            timer_next = TMR_W'(E_PULSE_CYC);
          end else begin
            p_next = 1'b1;
            timer_next = pulse_cyc(att_reg);
          end
          state_next = ST_PULSE_ON;
        end
      end
      ST_PULSE_ON: begin
        if (timer_reg == '0) begin
          p_next = 1'b0;
          e_next = 1'b0;
          timer_next = erase_reg ? TMR_W'(CYC_E_CLR) : TMR_W'(CYC_P_CLR);
          state_next = ST_PULSE_OFF;
        end
      end
      ST_PULSE_OFF: begin
        if (timer_reg == '0) begin
          if (!erase_reg && att_reg <= ATT_W'(SHORT_ATTEMPTS)) begin
            p_next = 1'b1;
            timer_next = TMR_W'(CYC_P_ADD);
            state_next = ST_ADD_ON;
          end else begin
            psu_next = 1'b0;
            esu_next = 1'b0;
            timer_next = erase_reg ? TMR_W'(CYC_ESU_CLR) : TMR_W'(CYC_PSU_CLR);
            state_next = ST_SETUP_OFF;
          end
        end
      end
      ST_ADD_ON: begin
        if (timer_reg == '0) begin
          p_next = 1'b0;
          timer_next = TMR_W'(CYC_P_CLR);
          state_next = ST_ADD_OFF;
        end
      end
      ST_ADD_OFF: begin
        if (timer_reg == '0) begin
          psu_next = 1'b0;
          timer_next = TMR_W'(CYC_PSU_CLR);
          state_next = ST_SETUP_OFF;
        end
      end
      ST_SETUP_OFF: begin
        if (timer_reg == '0) begin
          pv_next = ~erase_reg;
          ev_next = erase_reg;
          timer_next = erase_reg ? TMR_W'(CYC_EV_SET) : TMR_W'(CYC_PV_SET);
          idx_next = '0;
          miss_next = 1'b0;
          state_next = ST_VFY_ON;
        end
      end
      ST_VFY_ON: begin
        if (timer_reg == '0) begin
          fwr_next = 1'b1; // dummy write before each read
          faddr_next = byte_addr(base_reg, idx_reg);
          fwdata_next = ERASED_BYTE;
          timer_next = TMR_W'(CYC_DUMMY);
          state_next = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (timer_reg == '0) begin
          frd_next = 1'b1;
          timer_next = TMR_W'(CYC_RD_WAIT);
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (timer_reg == '0) begin
          state_next = ST_CMP;
        end
      end
      ST_CMP: begin
        if (rd_sync_reg != (erase_reg ? ERASED_BYTE : buf_rdata)) begin
          miss_next = 1'b1;
        end
        if (idx_reg == LAST_IDX) begin
          pv_next = 1'b0;
          ev_next = 1'b0;
          timer_next = erase_reg ? TMR_W'(CYC_EV_CLR) : TMR_W'(CYC_PV_CLR);
          state_next = ST_VFY_OFF;
        end else begin
          idx_next = idx_reg + 1'b1;
          timer_next = '0;
          state_next = ST_VFY_ON;
        end
      end
      ST_VFY_OFF: begin
        if (timer_reg == '0) begin
          if (miss_reg && att_reg < (erase_reg ? ATT_W'(ERASE_MAX) : ATT_W'(PROG_MAX))) begin
            att_next = att_reg + 1'b1;
            idx_next = '0;
            if (erase_reg) begin
              esu_next = 1'b1;
              timer_next = TMR_W'(ESU_SET_CYC);
              state_next = ST_SETUP_ON;
            end else begin
              state_next = ST_LOAD_RD;
            end
          end else begin
            fail_next = miss_reg;
            swe_next = 1'b0;
            timer_next = TMR_W'(SWE_CLR_CYC);
            state_next = ST_SWE_OFF;
          end
        end
      end
      ST_SWE_OFF: begin
        if (timer_reg == '0) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      idx_reg <= '0;
      att_reg <= '0;
      {erase_reg, miss_reg, busy_reg, done_reg, fail_reg} <= 5'h00;
      {swe_reg, psu_reg, p_reg, pv_reg, esu_reg, e_reg, ev_reg} <= 7'h00;
      faddr_reg <= '0;
      fwdata_reg <= 8'h00;
      fwr_reg <= 1'b0;
      frd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      idx_reg <= idx_next;
      att_reg <= att_next;
      {erase_reg, miss_reg, busy_reg, done_reg, fail_reg} <=
        {erase_next, miss_next, busy_next, done_next, fail_next};
      {swe_reg, psu_reg, p_reg, pv_reg, esu_reg, e_reg, ev_reg} <=
        {swe_next, psu_next, p_next, pv_next, esu_next, e_next, ev_next};
      faddr_reg <= faddr_next;
      fwdata_reg <= fwdata_next;
      fwr_reg <= fwr_next;
      frd_reg <= frd_next;
    end
  end

  // device control pins
  assign software_write_enable_bit = swe_reg;
  assign program_setup_bit = psu_reg;
  assign program_pulse_bit = p_reg;
  assign program_verify_bit = pv_reg;
  assign erase_setup_bit = esu_reg;
  assign erase_pulse_bit = e_reg;
  assign erase_verify_bit = ev_reg;
  assign flash_addr = faddr_reg;
  assign flash_wdata = fwdata_reg;
  assign flash_write = fwr_reg;
  assign flash_read = frd_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks: cycles since the control bits or a write last changed
  logic [6:0] ctl_vec;
  logic [TMR_W-1:0] since_reg, since_wr_reg;
  assign ctl_vec = {swe_reg, psu_reg, p_reg, pv_reg, esu_reg, e_reg, ev_reg};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_reg <= '0;
      since_wr_reg <= '0;
    end else begin
      since_reg <= ($changed(ctl_vec)) ? '0 : since_reg + 1'b1;
      since_wr_reg <= fwr_reg ? '0 : since_wr_reg + 1'b1;
    end
  end

  sequence s_swe_held;
    software_write_enable_bit && since_reg >= TMR_W'(CYC_SWE_SET);
  endsequence

  // one edge after the pulse bit dropped; since_reg then holds the timer load
  sequence s_pulse_ended;
    program_pulse_bit ##1 !program_pulse_bit;
  endsequence

  AST_SWE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(program_setup_bit) || $rose(erase_setup_bit)) |-> s_swe_held)
    else $error("setup bit set too soon after write enable");

  AST_PSU_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(program_pulse_bit) && state_reg == ST_PULSE_ON
    |-> program_setup_bit && since_reg >= TMR_W'(PSU_SET_CYC))
    else $error("program pulse set too soon");

  AST_P_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    s_pulse_ended |-> since_reg == pulse_cyc(att_reg) || since_reg == TMR_W'(CYC_P_ADD))
    else $error("program pulse width wrong");

  AST_PV_AFTER_PSU: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(program_verify_bit) |-> since_reg >= TMR_W'(CYC_PSU_CLR))
    else $error("program verify set too soon");

  AST_DUMMY_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    flash_read |-> since_wr_reg >= TMR_W'(CYC_DUMMY)
    && (program_verify_bit || erase_verify_bit))
    else $error("verify read too soon after dummy write");

  AST_SWE_OFF_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(software_write_enable_bit) |-> busy_reg [*8])
    else $error("done too soon after write enable clear");

  AST_DONE_LATE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done_reg) |-> since_reg >= TMR_W'(SWE_CLR_CYC) && !software_write_enable_bit)
    else $error("sequence ended before write enable recovery");

  AST_E_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(erase_pulse_bit) |-> since_reg == TMR_W'(E_PULSE_CYC)
    && since_reg < TMR_W'(CYC_E_PULSE_MAX))
    else $error("erase pulse width wrong");

  AST_EV_AFTER_ESU: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(erase_verify_bit) |-> since_reg >= TMR_W'(CYC_ESU_CLR) && !erase_pulse_bit)
    else $error("erase verify set too soon");

  AST_ATT_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    att_reg <= (erase_reg ? ATT_W'(ERASE_MAX) : ATT_W'(PROG_MAX)))
    else $error("attempt count beyond limit");

endmodule // fps_seq

// ### inc/fps_pkg.sv
package fps_pkg;

  // clock rate and derived scaling
  localparam int CLK_MHZ = 100;
  localparam int US_PER_MS = 1000;

  // least wait times in microseconds, pulse times as nominal
  localparam int T_SWE_SET_US = 1;
  localparam int T_PSU_SET_US = 50;
  localparam int T_P_SHORT_US = 30;
  localparam int T_P_LONG_US = 200;
  localparam int T_P_ADD_US = 10;
  localparam int T_P_CLR_US = 5;
  localparam int T_PSU_CLR_US = 5;
  localparam int T_PV_SET_US = 4;
  localparam int T_DUMMY_US = 2;
  localparam int T_PV_CLR_US = 2;
  localparam int T_SWE_CLR_US = 100;
  localparam int T_ESU_SET_US = 100;
  localparam int T_E_PULSE_MS = 10;
  localparam int T_E_PULSE_MAX_MS = 100;
  localparam int T_E_CLR_US = 10;
  localparam int T_ESU_CLR_US = 10;
  localparam int T_EV_SET_US = 20;
  localparam int T_EV_CLR_US = 4;

  // the same times as clock cycles
  localparam int CYC_SWE_SET = T_SWE_SET_US * CLK_MHZ;
  localparam int CYC_PSU_SET = T_PSU_SET_US * CLK_MHZ;
  localparam int CYC_P_SHORT = T_P_SHORT_US * CLK_MHZ;
  localparam int CYC_P_LONG = T_P_LONG_US * CLK_MHZ;
  localparam int CYC_P_ADD = T_P_ADD_US * CLK_MHZ;
  localparam int CYC_P_CLR = T_P_CLR_US * CLK_MHZ;
  localparam int CYC_PSU_CLR = T_PSU_CLR_US * CLK_MHZ;
  localparam int CYC_PV_SET = T_PV_SET_US * CLK_MHZ;
  localparam int CYC_DUMMY = T_DUMMY_US * CLK_MHZ;
  localparam int CYC_PV_CLR = T_PV_CLR_US * CLK_MHZ;
  localparam int CYC_SWE_CLR = T_SWE_CLR_US * CLK_MHZ;
  localparam int CYC_ESU_SET = T_ESU_SET_US * CLK_MHZ;
  localparam int CYC_E_PULSE = T_E_PULSE_MS * US_PER_MS * CLK_MHZ;
  localparam int CYC_E_PULSE_MAX = T_E_PULSE_MAX_MS * US_PER_MS * CLK_MHZ;
  localparam int CYC_E_CLR = T_E_CLR_US * CLK_MHZ;
  localparam int CYC_ESU_CLR = T_ESU_CLR_US * CLK_MHZ;
  localparam int CYC_EV_SET = T_EV_SET_US * CLK_MHZ;
  localparam int CYC_EV_CLR = T_EV_CLR_US * CLK_MHZ;
  localparam int CYC_RD_WAIT = 4;

  // attempt limits and unit size
  localparam int PROG_MAX = 1000;
  localparam int ERASE_MAX = 120;
  localparam int SHORT_ATTEMPTS = 6;
  localparam int UNIT_BYTES = 128;
  localparam int IDX_W = 7;
  localparam int ATT_W = 10;
  localparam int TMR_W = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_BASE = 5'h08;
  localparam logic [4:0] REG_BUFIDX = 5'h0C;
  localparam logic [4:0] REG_BUFDATA = 5'h10;

  // field positions
  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam int STAT_ERASE_BIT = 3;
  localparam int STAT_ATT_LSB = 16;

  // reset values
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [IDX_W-1:0] BUFIDX_RST = 7'h00;

  typedef enum logic [4:0] {
    ST_IDLE, ST_SWE_ON, ST_LOAD_RD, ST_LOAD_WR, ST_SETUP_ON, ST_PULSE_ON,
    ST_PULSE_OFF, ST_ADD_ON, ST_ADD_OFF, ST_SETUP_OFF, ST_VFY_ON, ST_DUMMY,
    ST_READ, ST_CMP, ST_VFY_OFF, ST_SWE_OFF
  } fps_state_t;

endpackage

// ### src/fps_buf.sv
`timescale 1ns/1ps
module fps_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // fps_buf

// ### sim/fps_flash_model.sv
`timescale 1ns/1ps
module fps_flash_model
  import fps_pkg::*;
#(
  parameter int PSU_SET = 50,
  parameter int ESU_SET = 100,
  parameter int E_PULSE = 1000,
  parameter int SWE_CLR = 100
) (
  input wire logic clk,
  input wire logic [6:0] bits,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_write,
  input wire logic flash_read,
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [UNIT_BYTES];
  logic [7:0] lat [UNIT_BYTES];
  logic [7:0] rd_q = 8'h00;
  logic [6:0] b_q = 7'h00;
  logic [6:0] up, dn;
  logic pm = 1'b0;
  int viol = 0;
  int now = 0;
  int hold = 0;
  int t_we, t_su, t_pu, t_pd, t_sd, t_vu, t_wr, t_vd;
  int t_off = -1000000;
  //////////////////////////////////////////////////////////////////////////////
  // data stands from the strobe on, then the line wanders
  assign flash_rdata = flash_read ? mem[flash_addr[6:0]] : rd_q;
  assign up = bits & ~b_q;
  assign dn = ~bits & b_q;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // counts a step that came too soon
  task automatic need(input int t0, input int cyc);
    if (now - t0 < cyc) viol++;
  endtask
  // watch every control edge and strobe
  always @(posedge clk) begin
    now++;
    b_q <= bits;
    if (up[6]) begin need(t_off, SWE_CLR); t_we = now; end
    if (up[5] | up[2]) begin need(t_we, CYC_SWE_SET); t_su = now; pm = up[5]; end
    if (up[4]) begin need(t_su, PSU_SET); t_pu = now; end
    if (up[1]) begin need(t_su, ESU_SET); t_pu = now; end
    if (dn[4]) begin
      if (!(now - t_pu inside {[800:1200], [2800:3200]})) viol++;
      foreach (mem[i]) mem[i] &= lat[i];
      t_pd = now;
    end
    if (dn[1]) begin
      if (!(now - t_pu inside {[E_PULSE:E_PULSE * 10]})) viol++;
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      t_pd = now;
    end
    if (dn[5] | dn[2]) begin need(t_pd, pm ? 500 : 1000); t_sd = now; end
    if (up[3] | up[0]) begin need(t_sd, pm ? 500 : 1000); t_vu = now; end
    if (dn[3] | dn[0]) t_vd = now;
    if (dn[6]) begin need(t_vd, pm ? 200 : 400); t_off = now; end
    if (flash_write) begin
      need(t_off, SWE_CLR);
      if (bits[3] | bits[0]) begin need(t_vu, pm ? 400 : 2000); t_wr = now; end
      else lat[flash_addr[6:0]] = flash_wdata;
    end
    if (flash_read) begin need(t_wr, 200); rd_q <= mem[flash_addr[6:0]]; hold = 6; end
    else if (hold > 0) hold--;
    else rd_q <= ~rd_q;
  end
endmodule // fps_flash_model

// ### sim/tb_fps_seq.sv
`timescale 1ns/1ps
module tb_fps_seq;
  import fps_pkg::*;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q, base;
  logic avs_waitrequest, flash_write, flash_read;
  logic [6:0] ctl;
  logic [15:0] flash_addr;
  logic [7:0] flash_wdata, flash_rdata;
  logic [7:0] data [UNIT_BYTES];
  logic [31:0] rng = 32'h0000_0030;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  //////////////////////////////////////////////////////////////////////////////
  fps_seq #(.PSU_SET_CYC(50), .P_LONG_CYC(200), .SWE_CLR_CYC(100), .ESU_SET_CYC(100),
    .E_PULSE_CYC(1000)) fps_seq_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .software_write_enable_bit(ctl[6]), .program_setup_bit(ctl[5]),
    .program_pulse_bit(ctl[4]), .program_verify_bit(ctl[3]), .erase_setup_bit(ctl[2]),
    .erase_pulse_bit(ctl[1]), .erase_verify_bit(ctl[0]), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_write(flash_write), .flash_read(flash_read),
    .flash_rdata(flash_rdata));
  fps_flash_model fps_flash_model_inst (.clk(clk), .bits(ctl), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_write(flash_write), .flash_read(flash_read),
    .flash_rdata(flash_rdata));
  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      test_done();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // status expected once an operation passed on its first attempt
  function automatic logic [31:0] done_word(input logic er);
    return (32'h1 << STAT_DONE_BIT) | ({31'h0, er} << STAT_ERASE_BIT) | (32'h1 << STAT_ATT_LSB);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
  endtask
  // start an operation, try to move the base meanwhile, poll to the end
  task automatic run(input logic [31:0] cmd, input logic er);
    int i;
    bus(1'b1, REG_CTRL, cmd);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("busy", q[STAT_BUSY_BIT], 32'h1);
    rng = xs(rng);
    bus(1'b1, REG_BASE, rng);
    i = 0;
    do begin bus(1'b0, REG_STATUS, 32'h0); i++; end
    while (q[STAT_BUSY_BIT] !== 1'b0 && i < 60000);
    chk("status", q, done_word(er));
    chk("steps", fps_flash_model_inst.viol, 0);
    bus(1'b0, REG_BASE, 32'h0);
    chk("base_kept", q, base);
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence: reset values, erase, load, program with both start bits
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_rst", q, 32'h0);
    bus(1'b0, REG_BUFIDX, 32'h0);
    chk("bufidx_rst", q, {25'h0, BUFIDX_RST});
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    base = xs(rng) & 32'h0000_FF80;
    bus(1'b1, REG_BASE, base);
    run(32'h2, 1'b1);
    for (int i = 0; i < UNIT_BYTES; i++) chk("erased", fps_flash_model_inst.mem[i], 8'hFF);
    bus(1'b1, REG_BUFIDX, 32'h0);
    for (int i = 0; i < UNIT_BYTES; i++) begin
      rng = xs(rng);
      data[i] = rng[7:0];
      bus(1'b1, REG_BUFDATA, {rng[31:8], data[i]});
    end
    bus(1'b0, REG_BUFIDX, 32'h0);
    chk("bufidx_wrap", q, 32'h0);
    run(32'h3, 1'b0);
    chk("addr_last", {16'h0, flash_addr}, {16'h0, base[15:0] + 16'(UNIT_BYTES - 1)});
    for (int i = 0; i < UNIT_BYTES; i++) chk("byte", fps_flash_model_inst.mem[i], data[i]);
    avs_read <= 1'b0;
    @(posedge clk);
    test_done();
  end
endmodule // tb_fps_seq
